// file: logic/vbs_timing.sv
// Purpose: Vertical line counter with blank, CRT sync and panel sync compares
// Assumes: Horizontal timing supplies line-end and mid-line pulses on mclk_i
// Notes: All compares work on lines; interlace counts twice per line
//
// Operation
// (R1) Vertical blank turns on at the line equal to the low blank-start field plus one.
// (R2) For interlace, software sets blank start to the active-line value plus one.
// (R3) Every vertical blank and sync value is a count of lines.
// (R4) Interlaced blanking has no border and is taken from the total and active settings.
// (R5) CRT vertical sync turns off at the line equal to bits 26:16 of its register plus one.
// (R6) CRT vertical sync turns on at the line equal to bits 10:0 of its register plus one.
// (R7) In interlace the line counter steps twice in each horizontal line.
// (R8) With an odd total in interlace, sync starts mid-line in one field and at line end next.
// (R9) Panel vertical sync turns off at the line equal to the panel stop field plus two.
// (R10) Panel vertical sync turns on at the line equal to the panel begin field plus two.
// (R11) The panel vertical sync is latched by the panel horizontal sync before output.
// (R12) The active-line setting is displayed lines minus one, the interlace blank reference.
// (R13) The total-line setting is all lines minus one and sets the counter wrap point.
// (R14) Each output holds from its start match until its end match.
// (R15) Software writes zeros into reserved bit ranges.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module vbs_timing (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic hline_end_i,
    input wire logic hline_mid_i,
    input wire logic panel_hsync_i,
    output logic vblank_o,
    output logic crt_vsync_o,
    output logic panel_vsync_o,
    output logic field_o
);

    typedef struct packed {
        logic [10:0] total;
        logic [10:0] active;
        logic [10:0] blank_end;
        logic [10:0] blank_start;
        logic [10:0] sync_end;
        logic [10:0] sync_start;
        logic [10:0] panel_vsync_stop_line;
        logic [10:0] panel_vsync_begin_line;
        logic interlace;
        logic run;
        logic [10:0] line;
        logic field;
        logic hs_prev;
        logic panel_out;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } vbs_state_t;

    vbs_state_t s;
    vbs_state_t next_s;

    logic setup;
    logic access;
    logic advance;
    logic wrap;
    logic hs_rise;
    logic mapped;
    logic [10:0] blank_start_use;
    logic [10:0] blank_end_use;
    logic blank_int;
    logic crt_int;
    logic panel_int;

    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i && s.ready;

    // Counter steps on whole lines only, and on half lines when interlaced
    assign advance = s.run && (hline_end_i || (s.interlace && hline_mid_i)); // R3 R7
    assign wrap = (s.line == s.total); // R13
    assign hs_rise = panel_hsync_i && !s.hs_prev;

    assign mapped = (paddr_i == vbs_pkg::TOTAL_ACTIVE_ADDR)
        || (paddr_i == vbs_pkg::BLANK_ADDR)
        || (paddr_i == vbs_pkg::CRT_SYNC_ADDR)
        || (paddr_i == vbs_pkg::PANEL_SYNC_ADDR)
        || (paddr_i == vbs_pkg::CTRL_ADDR)
        || (paddr_i == vbs_pkg::STATUS_ADDR);

    // No border when interlaced, so blanking follows active and total directly
    always_comb begin
        if (s.interlace) begin
            blank_start_use = s.active + vbs_pkg::ILACE_BLANK_ADD; // R2 R4 R12
            blank_end_use = vbs_pkg::ILACE_BLANK_END; // R4
        end else begin
            blank_start_use = s.blank_start;
            blank_end_use = s.blank_end;
        end
    end

    always_comb begin
        next_s = s;
        next_s.hs_prev = panel_hsync_i;

        // Line counter and field toggle
        if (advance) begin
            if (wrap) begin
                next_s.line = vbs_pkg::LINE_RESET; // R13
                // Odd total with half-line steps alternates the field phase
                next_s.field = !s.field; // R8
            end else begin
                next_s.line = s.line + 11'h001; // R3 R7
            end
        end
        if (!s.run) begin
            next_s.line = vbs_pkg::LINE_RESET;
            next_s.field = 1'b0;
        end

        // Panel sync leaves only on a panel hsync edge, to meet panel timing
        if (hs_rise) begin
            next_s.panel_out = panel_int; // R11
        end

        // APB: answer one cycle after setup, ready falls after the access
        next_s.ready = 1'b0;
        next_s.slverr = 1'b0;
        if (setup) begin
            next_s.ready = 1'b1;
            next_s.slverr = !mapped;
            next_s.rdata = vbs_pkg::DATA_ZERO;
            if (!pwrite_i) begin
                if (paddr_i == vbs_pkg::TOTAL_ACTIVE_ADDR) begin
                    next_s.rdata[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB] = s.total;
                    next_s.rdata[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB] = s.active;
                end else if (paddr_i == vbs_pkg::BLANK_ADDR) begin
                    next_s.rdata[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB] = s.blank_end;
                    next_s.rdata[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB] = s.blank_start;
                end else if (paddr_i == vbs_pkg::CRT_SYNC_ADDR) begin
                    next_s.rdata[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB] = s.sync_end;
                    next_s.rdata[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB] = s.sync_start;
                end else if (paddr_i == vbs_pkg::PANEL_SYNC_ADDR) begin
                    next_s.rdata[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB] = s.panel_vsync_stop_line;
                    next_s.rdata[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB] = s.panel_vsync_begin_line;
                end else if (paddr_i == vbs_pkg::CTRL_ADDR) begin
                    next_s.rdata[vbs_pkg::CTRL_INTERLACE_BIT] = s.interlace;
                    next_s.rdata[vbs_pkg::CTRL_RUN_BIT] = s.run;
                end else if (paddr_i == vbs_pkg::STATUS_ADDR) begin
                    next_s.rdata[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB] = s.line;
                    next_s.rdata[vbs_pkg::STAT_FIELD_BIT] = s.field;
                    next_s.rdata[vbs_pkg::STAT_BLANK_BIT] = vblank_o;
                    next_s.rdata[vbs_pkg::STAT_CRT_BIT] = crt_vsync_o;
                    next_s.rdata[vbs_pkg::STAT_PANEL_BIT] = s.panel_out;
                end
            end
        end

        // Writes land at the access edge; reserved bits are not stored // R15
        if (access && pwrite_i) begin
            if (paddr_i == vbs_pkg::TOTAL_ACTIVE_ADDR) begin
                next_s.total = pwdata_i[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB]; // R13
                next_s.active = pwdata_i[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB]; // R12
            end else if (paddr_i == vbs_pkg::BLANK_ADDR) begin
                next_s.blank_end = pwdata_i[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB];
                next_s.blank_start = pwdata_i[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB]; // R1
            end else if (paddr_i == vbs_pkg::CRT_SYNC_ADDR) begin
                next_s.sync_end = pwdata_i[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB]; // R5
                next_s.sync_start = pwdata_i[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB]; // R6
            end else if (paddr_i == vbs_pkg::PANEL_SYNC_ADDR) begin
                next_s.panel_vsync_stop_line = pwdata_i[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB]; // R9
                next_s.panel_vsync_begin_line = pwdata_i[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB]; // R10
            end else if (paddr_i == vbs_pkg::CTRL_ADDR) begin
                next_s.interlace = pwdata_i[vbs_pkg::CTRL_INTERLACE_BIT];
                next_s.run = pwdata_i[vbs_pkg::CTRL_RUN_BIT];
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Blank compare, offset one line
    vbs_cmp #(
        .OFFSET(vbs_pkg::CRT_CMP_OFFSET)
    ) u_blank (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .line_i(s.line),
        .start_i(blank_start_use),
        .end_i(blank_end_use),
        .active_o(blank_int)
    );

    // CRT sync compare, offset one line
    vbs_cmp #(
        .OFFSET(vbs_pkg::CRT_CMP_OFFSET)
    ) u_crt (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .line_i(s.line),
        .start_i(s.sync_start),
        .end_i(s.sync_end),
        .active_o(crt_int)
    );

    // Panel sync compare, offset two lines, ahead of the hsync latch
    vbs_cmp #(
        .OFFSET(vbs_pkg::PANEL_CMP_OFFSET)
    ) u_panel (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .line_i(s.line),
        .start_i(s.panel_vsync_begin_line),
        .end_i(s.panel_vsync_stop_line),
        .active_o(panel_int)
    );

    assign vblank_o = blank_int;
    assign crt_vsync_o = crt_int;
    assign panel_vsync_o = s.panel_out;
    assign field_o = s.field;
    assign prdata_o = s.rdata;
    assign pready_o = s.ready;
    assign pslverr_o = s.slverr;

    line_wraps_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
        (advance && wrap) |=> (s.line == vbs_pkg::LINE_RESET) && (s.field != $past(s.field)))
        else $error("counter did not wrap at total");

    line_steps_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
        (advance && !wrap) |=> (s.line == $past(s.line) + 11'h001))
        else $error("counter did not step by one line");

    line_holds_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
        (s.run && !hline_end_i && !(s.interlace && hline_mid_i)) |=> $stable(s.line))
        else $error("counter moved without a line event");

    mid_step_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
        (s.run && s.interlace && hline_mid_i && !wrap) |=> (s.line != $past(s.line)))
        else $error("interlace mid-line step missed");

    ilace_blank_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
        (s.interlace && s.line == s.active + 11'h002) |=> blank_int)
        else $error("interlace blank not taken from active");

    panel_latch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
        hs_rise |=> (panel_vsync_o == $past(panel_int)))
        else $error("panel sync not latched on hsync edge");

    panel_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
        !hs_rise |=> $stable(panel_vsync_o))
        else $error("panel sync changed without hsync edge");

    crt_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6
        (access && pwrite_i && paddr_i == vbs_pkg::CRT_SYNC_ADDR)
        |=> (s.sync_start == $past(pwdata_i[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB]))
        && (s.sync_end == $past(pwdata_i[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB])))
        else $error("sync register write not stored");

    apb_answer_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        setup |=> pready_o ##1 !pready_o)
        else $error("ready not one cycle after setup");

    unmapped_err_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (setup && !mapped) |=> pslverr_o)
        else $error("unmapped address not refused");

    run_low_clears_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
        !s.run |=> (s.line == vbs_pkg::LINE_RESET) && !s.field)
        else $error("counter not cleared while stopped");

    field_holds_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R8
        (s.run && !(advance && wrap)) |=> $stable(s.field))
        else $error("field changed without a wrap");

    mid_ignored_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
        (s.run && !s.interlace && hline_mid_i && !hline_end_i) |=> $stable(s.line))
        else $error("mid-line pulse stepped a progressive counter");

    blank_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
        (!s.interlace && s.line == s.blank_start + 11'(vbs_pkg::CRT_CMP_OFFSET))
        |=> vblank_o)
        else $error("blank not raised at start plus one");

    ilace_blank_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
        (s.interlace && s.line == vbs_pkg::LINE_RESET
        && s.line != blank_start_use + 11'(vbs_pkg::CRT_CMP_OFFSET)) |=> !vblank_o)
        else $error("interlace blank not ended at the wrap");

    crt_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6
        (s.line == s.sync_start + 11'(vbs_pkg::CRT_CMP_OFFSET)) |=> crt_vsync_o)
        else $error("crt sync not raised at start plus one");

    crt_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
        (s.line == s.sync_end + 11'(vbs_pkg::CRT_CMP_OFFSET)
        && s.line != s.sync_start + 11'(vbs_pkg::CRT_CMP_OFFSET)) |=> !crt_vsync_o)
        else $error("crt sync not dropped at end plus one");

    panel_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
        (s.line == s.panel_vsync_begin_line + 11'(vbs_pkg::PANEL_CMP_OFFSET)) |=> panel_int)
        else $error("panel sync not raised at begin plus two");

    panel_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R9
        (s.line == s.panel_vsync_stop_line + 11'(vbs_pkg::PANEL_CMP_OFFSET)
        && s.line != s.panel_vsync_begin_line + 11'(vbs_pkg::PANEL_CMP_OFFSET)) |=> !panel_int)
        else $error("panel sync not dropped at stop plus two");

    total_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
        (access && pwrite_i && paddr_i == vbs_pkg::TOTAL_ACTIVE_ADDR)
        |=> (s.total == $past(pwdata_i[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB])))
        else $error("total line write not stored");

    active_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
        (access && pwrite_i && paddr_i == vbs_pkg::TOTAL_ACTIVE_ADDR)
        |=> (s.active == $past(pwdata_i[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB])))
        else $error("active line write not stored");

    blank_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
        (access && pwrite_i && paddr_i == vbs_pkg::BLANK_ADDR)
        |=> (s.blank_start == $past(pwdata_i[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB]))
        && (s.blank_end == $past(pwdata_i[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB])))
        else $error("blank register write not stored");

    panel_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
        (access && pwrite_i && paddr_i == vbs_pkg::PANEL_SYNC_ADDR)
        |=> (s.panel_vsync_begin_line == $past(pwdata_i[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB]))
        && (s.panel_vsync_stop_line == $past(pwdata_i[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB])))
        else $error("panel register write not stored");

    ctrl_store_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
        (access && pwrite_i && paddr_i == vbs_pkg::CTRL_ADDR)
        |=> (s.interlace == $past(pwdata_i[vbs_pkg::CTRL_INTERLACE_BIT]))
        && (s.run == $past(pwdata_i[vbs_pkg::CTRL_RUN_BIT])))
        else $error("control write not stored");

    unmapped_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (access && pwrite_i && !mapped)
        |=> $stable(s.total) && $stable(s.active) && $stable(s.sync_start)
        && $stable(s.sync_end) && $stable(s.interlace) && $stable(s.run))
        else $error("unmapped write changed a register");

    crt_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6
        (setup && !pwrite_i && paddr_i == vbs_pkg::CRT_SYNC_ADDR)
        |=> (prdata_o[vbs_pkg::LO_MSB:vbs_pkg::LO_LSB] == $past(s.sync_start))
        && (prdata_o[vbs_pkg::HI_MSB:vbs_pkg::HI_LSB] == $past(s.sync_end)))
        else $error("sync register read wrong");

    reserved_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (setup && !pwrite_i)
        |=> (prdata_o[vbs_pkg::DATA_W-1:vbs_pkg::HI_MSB+1] == '0)
        && (prdata_o[vbs_pkg::HI_LSB-1:vbs_pkg::LO_MSB+1] == '0))
        else $error("reserved read bits not zero");

    err_only_unmapped_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (setup && mapped) |=> !pslverr_o)
        else $error("mapped address refused");

endmodule // vbs_timing

// file: shared/vbs_pkg.sv
// Purpose: Shared constants for the vertical blank and sync timing block
// Assumes: APB slave with 32-bit data, 16-bit byte address
// Notes: Line fields are 11 bits wide, placed low (10:0) or high (26:16)
package vbs_pkg;

    localparam int LINE_W = 11;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [15:0] TOTAL_ACTIVE_ADDR = 16'h8340;
    localparam logic [15:0] BLANK_ADDR = 16'h8344;
    localparam logic [15:0] CRT_SYNC_ADDR = 16'h8348;
    localparam logic [15:0] PANEL_SYNC_ADDR = 16'h834c;
    localparam logic [15:0] CTRL_ADDR = 16'h8380;
    localparam logic [15:0] STATUS_ADDR = 16'h8384;

    // Field positions
    localparam int LO_LSB = 0;
    localparam int LO_MSB = 10;
    localparam int HI_LSB = 16;
    localparam int HI_MSB = 26;
    localparam int CTRL_INTERLACE_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam int STAT_FIELD_BIT = 16;
    localparam int STAT_BLANK_BIT = 17;
    localparam int STAT_CRT_BIT = 18;
    localparam int STAT_PANEL_BIT = 19;

    // Reset values
    localparam logic [10:0] LINE_RESET = 11'h000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // Compare offsets, in lines, added to each programmed field
    localparam int CRT_CMP_OFFSET = 1;
    localparam int PANEL_CMP_OFFSET = 2;

    // Interlaced blanking: start from active plus one, end at the wrap
    localparam logic [10:0] ILACE_BLANK_ADD = 11'h001;
    localparam logic [10:0] ILACE_BLANK_END = 11'h7ff;

endpackage

// file: logic/vbs_cmp.sv
// Purpose: One start/end line comparator driving a held level
// Assumes: line_i is the registered vertical line counter
// Notes: Start match wins when start and end fall on the same line
`timescale 1ns/1ps
module vbs_cmp #(
    parameter int OFFSET = 1
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [10:0] line_i,
    input wire logic [10:0] start_i,
    input wire logic [10:0] end_i,
    output logic active_o
);

    typedef struct packed {
        logic level;
    } vbs_cmp_state_t;

    vbs_cmp_state_t s;
    vbs_cmp_state_t next_s;
    logic [10:0] start_line;
    logic [10:0] end_line;

    assign start_line = start_i + 11'(OFFSET);
    assign end_line = end_i + 11'(OFFSET);

    always_comb begin
        next_s = s;
        if (line_i == start_line) begin
            next_s.level = 1'b1; // R1 R6 R10
        end else if (line_i == end_line) begin
            next_s.level = 1'b0; // R5 R9
        end
        // Between the two matches the level simply holds // R14
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign active_o = s.level;

    start_sets_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
        (line_i == start_line) |=> active_o)
        else $error("level not set after start match");

    end_clears_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
        (line_i == end_line && line_i != start_line) |=> !active_o)
        else $error("level not cleared after end match");

    level_holds_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
        (line_i != end_line && line_i != start_line) |=> $stable(active_o))
        else $error("level changed without a match");

endmodule // vbs_cmp

// file: tb/vbs_hsync_model.sv
// Purpose: Horizontal timing source and sync receiver seen by the block
// Assumes: One line lasts HLEN clocks; panel hsync sits clear of line events
// Notes: Counts CRT vsync pulses as a crude monitor frame count
`timescale 1ns/1ps
module vbs_hsync_model #(
    parameter int HLEN = 16
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic crt_vsync_i,
    output logic hline_end_o,
    output logic hline_mid_o,
    output logic panel_hsync_o,
    output int frames_o
);
    int cnt;
    logic vs_q;
    // Hsync high mid-first-half so the latched vsync never races a line step
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 0;
            hline_end_o <= 1'b0;
            hline_mid_o <= 1'b0;
            panel_hsync_o <= 1'b0;
            frames_o <= 0;
            vs_q <= 1'b0;
        end else begin
            cnt <= (cnt == HLEN - 1) ? 0 : cnt + 1;
            hline_end_o <= (cnt == HLEN - 2);
            hline_mid_o <= (cnt == HLEN / 2 - 2);
            panel_hsync_o <= (cnt >= 3 && cnt <= 5);
            vs_q <= crt_vsync_i;
            if (crt_vsync_i && !vs_q) begin
                frames_o <= frames_o + 1;
            end
        end
    end
endmodule // vbs_hsync_model

// file: tb/tb_vbs_timing.sv
// Purpose: Self-checking bench for the vertical blank and sync block
// Assumes: Reference counter mirrors the line, blank and sync levels
// Notes: Config only changes with run low, so reference and design agree
`timescale 1ns/1ps
module tb_vbs_timing;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, hend, hmid, phs, vblank, crt, pvs, field;
    int frames;
    logic [31:0] sh_ta = 0, sh_bl = 0, sh_crt = 0, sh_pn = 0, sh_ctl = 0;
    logic [10:0] r_line, bs, be;
    logic r_field, r_blank, r_crt, r_pint, r_pout, hs_q;
    int fails = 0;
    int tests_run = 0;
    int seed = 27305;
    always #4 mclk_i = ~mclk_i;

    vbs_timing i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .hline_end_i(hend), .hline_mid_i(hmid),
        .panel_hsync_i(phs), .vblank_o(vblank), .crt_vsync_o(crt), .panel_vsync_o(pvs),
        .field_o(field));
    vbs_hsync_model i_far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .crt_vsync_i(crt),
        .hline_end_o(hend), .hline_mid_o(hmid), .panel_hsync_o(phs), .frames_o(frames));

    function automatic logic lvl(logic cur, logic [10:0] ln, logic [10:0] st,
        logic [10:0] en, int off);
        if (ln == 11'(st + off)) return 1'b1;
        if (ln == 11'(en + off)) return 1'b0;
        return cur;
    endfunction

    assign bs = sh_ctl[0] ? sh_ta[10:0] + 11'h001 : sh_bl[10:0];
    assign be = sh_ctl[0] ? 11'h7ff : sh_bl[26:16];
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {r_line, r_field, r_blank, r_crt, r_pint, r_pout, hs_q} <= '0;
        end else begin
            if (!sh_ctl[1]) begin
                r_line <= 11'h000;
                r_field <= 1'b0;
            end else if (hend || (sh_ctl[0] && hmid)) begin
                r_line <= (r_line == sh_ta[26:16]) ? 11'h000 : r_line + 11'h001;
                r_field <= r_field ^ (r_line == sh_ta[26:16]);
            end
            r_blank <= lvl(r_blank, r_line, bs, be, 1);
            r_crt <= lvl(r_crt, r_line, sh_crt[10:0], sh_crt[26:16], 1);
            r_pint <= lvl(r_pint, r_line, sh_pn[10:0], sh_pn[26:16], 2);
            hs_q <= phs;
            if (phs && !hs_q) begin
                r_pout <= r_pint;
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(negedge mclk_i) begin
        if (rst_n_i) begin
            chk(vblank, r_blank);
            chk(crt, r_crt);
            chk(field, r_field);
            chk(pvs, r_pout);
        end
    end

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
        // Reserved bits never reach the shadow copies
        case (a)
            vbs_pkg::TOTAL_ACTIVE_ADDR: sh_ta <= d & 32'h07ff_07ff;
            vbs_pkg::BLANK_ADDR: sh_bl <= d & 32'h07ff_07ff;
            vbs_pkg::CRT_SYNC_ADDR: sh_crt <= d & 32'h07ff_07ff;
            vbs_pkg::PANEL_SYNC_ADDR: sh_pn <= d & 32'h07ff_07ff;
            default: sh_ctl <= d & 32'h0000_0003;
        endcase
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
        chk(er, experr);
    endtask

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk_i);
        fails++;
        give_verdict;
    end

    initial begin
        logic [31:0] w, rd;
        logic er;
        logic [10:0] tot, act, st, en;
        logic il;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rdchk(vbs_pkg::CRT_SYNC_ADDR, 32'h0, 1'b0);
        rdchk(16'h8390, 32'h0, 1'b1);
        // Reserved bits go out as zero, as software must
        w = $random(seed) & 32'h07ff_07ff;
        wr(vbs_pkg::CRT_SYNC_ADDR, w);
        rdchk(vbs_pkg::CRT_SYNC_ADDR, w, 1'b0);
        apb(1'b1, 16'h8390, ~w, rd, er);
        chk(er, 1'b1);
        rdchk(vbs_pkg::CRT_SYNC_ADDR, w, 1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(vbs_pkg::CTRL_ADDR, 32'h0);
            il = (i >= 4);
            tot = 11'(10 + $unsigned($random(seed)) % 30);
            // Interlace needs an odd line count, so an even total value
            if (il) tot = tot & 11'h7fe;
            act = tot - 11'(3 + $unsigned($random(seed)) % 4);
            st = 11'($unsigned($random(seed)) % tot);
            en = 11'($unsigned($random(seed)) % tot);
            if (i == 0) en = st;
            if (i == 1) st = 11'h7ff;
            wr(vbs_pkg::TOTAL_ACTIVE_ADDR, {5'h0, tot, 5'h0, act});
            wr(vbs_pkg::BLANK_ADDR, {5'h0, en, 5'h0, il ? act + 11'h001 : st});
            wr(vbs_pkg::CRT_SYNC_ADDR, {5'h0, en, 5'h0, st});
            wr(vbs_pkg::PANEL_SYNC_ADDR, {5'h0, st, 5'h0, en});
            rdchk(vbs_pkg::TOTAL_ACTIVE_ADDR, {5'h0, tot, 5'h0, act}, 1'b0);
            rdchk(vbs_pkg::BLANK_ADDR, {5'h0, en, 5'h0, il ? act + 11'h001 : st}, 1'b0);
            rdchk(vbs_pkg::PANEL_SYNC_ADDR, {5'h0, st, 5'h0, en}, 1'b0);
            // Let the panel latch settle so the expected status cannot move under the read
            repeat (20) @(posedge mclk_i);
            w = {12'h0, r_pout, r_crt, r_blank, r_field, 5'h0, r_line};
            rdchk(vbs_pkg::STATUS_ADDR, w, 1'b0);
            wr(vbs_pkg::CTRL_ADDR, {30'h0, 1'b1, il});
            rdchk(vbs_pkg::CTRL_ADDR, {30'h0, 1'b1, il}, 1'b0);
            repeat (3 * (int'(tot) + 1) * 16) @(posedge mclk_i);
        end
        wr(vbs_pkg::CTRL_ADDR, 32'h0);
        chk(frames > 0, 1'b1);
        give_verdict;
    end
endmodule // tb_vbs_timing
